// ### logic/eps_defines.vh
// constants for the nonvolatile program/erase sequencer
`ifndef EPS_DEFINES_VH
`define EPS_DEFINES_VH

// cpu-visible addresses
`define EPS_ARRAY_BASE    16'h0800
`define EPS_ARRAY_LAST    16'h09ff
`define EPS_DIV_HI_ADDR   16'hfe1a
`define EPS_DIV_LO_ADDR   16'hfe1b
`define EPS_NVCFG_ADDR    16'hfe1c
`define EPS_CTRL_ADDR     16'hfe1d
`define EPS_ACR_ADDR      16'hfe1f

// control register fields
`define EPS_CTRL_SPARE    7
`define EPS_CTRL_OFF      5
`define EPS_CTRL_MODE_HI  4
`define EPS_CTRL_MODE_LO  3
`define EPS_CTRL_LATCH    2
`define EPS_CTRL_AUTO     1
`define EPS_CTRL_ENABLE   0

// array configuration fields
`define EPS_ACR_SECURE    4
`define EPS_ACR_PROT_HI   3
`define EPS_ACR_PROT_LO   0

// operation modes
`define EPS_MODE_PROG     2'h0
`define EPS_MODE_BYTE_ER  2'h1
`define EPS_MODE_BLOCK_ER 2'h2
`define EPS_MODE_BULK_ER  2'h3

// reset and erased values
`define EPS_ERASED_BYTE   8'hff
`define EPS_NVCFG_RST     8'h10
`define EPS_CTRL_RST      8'h00
`define EPS_CFG_INDEX     10'h200

// timebase: 35 us at 25 MHz bus clock
`define EPS_TB_US         11'd35
`define EPS_CLK_MHZ       11'd25
`define EPS_TB_DIV_RST    (`EPS_TB_US * `EPS_CLK_MHZ)

`endif

// ### logic/eps_nvm_array.v
// byte array plus configuration byte with program and erase primitives
`timescale 1ns/1ns
`include "eps_defines.vh"
module eps_nvm_array #(
  parameter DEPTH = 512
) (
  // clock and reset
  input  wire       clk_sys,
  input  wire       resetn,
  // operation request
  input  wire       op_go,
  input  wire [1:0] op_mode,
  input  wire [9:0] op_idx,
  input  wire [7:0] op_data,
  input  wire [3:0] blk_en,
  // read port
  input  wire [9:0] rd_idx,
  output wire [7:0] rd_byte
);
  reg [7:0] mem_ff [0:DEPTH-1];
  reg [7:0] cfg_ff;
  integer   i;

  assign rd_byte = rd_idx[9] ? cfg_ff : mem_ff[rd_idx[8:0]];

  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      for (i = 0; i < DEPTH; i = i + 1) begin
        mem_ff[i] <= `EPS_ERASED_BYTE; // R1
      end
      cfg_ff <= `EPS_NVCFG_RST;
    end else if (op_go) begin
      case (op_mode)
        `EPS_MODE_PROG: begin
          // only ones can fall to zero
          if (op_idx[9])
            cfg_ff <= cfg_ff & op_data; // R2
          else
            mem_ff[op_idx[8:0]] <= mem_ff[op_idx[8:0]] & op_data; // R2
        end
        `EPS_MODE_BYTE_ER: begin
          if (op_idx[9])
            cfg_ff <= `EPS_ERASED_BYTE; // R16
          else
            mem_ff[op_idx[8:0]] <= `EPS_ERASED_BYTE; // R15
        end
        `EPS_MODE_BLOCK_ER: begin
          for (i = 0; i < DEPTH; i = i + 1) begin
            if (i[8:7] == op_idx[8:7] && blk_en[i[8:7]])
              mem_ff[i] <= `EPS_ERASED_BYTE; // R15
          end
        end
        default: begin
          // cfg byte untouched by block and bulk erase
          for (i = 0; i < DEPTH; i = i + 1) begin
            if (blk_en[i[8:7]])
              mem_ff[i] <= `EPS_ERASED_BYTE; // R16
          end
        end
      endcase
    end
  end
endmodule

// ### logic/eps_sequencer.v
// program/erase sequencer: control register, latch interlocks, timed sequence
// Summary of operation
// R1 - erased bits read one; erase spans one byte up to the whole array
// R2 - programming only clears bits, one byte per operation
// R3 - software erases a byte after eight programs, all-ones writes included
// R4 - protected blocks and locked bytes see no program or erase
// R5 - two-bit mode: program, byte, block, bulk erase; cleared by reset
// R6 - with latch set, valid array writes capture address and data, last wins
// R7 - with latch set, array reads return latched data and latch the address
// R8 - after latch set, control writes accepted only after a captured write; an array read also unlocks them here
// R9 - enable refused while latch clear or no valid address latched
// R10 - enable starts pump and timed sequence; mode frozen while enabled
// R11 - software must not read the array while enable is set
// R12 - auto mode clears enable early; software polls, not times
// R13 - manual mode: software times, clears enable, waits, then clears latch
// R14 - latch cannot clear while enabled; clearing both clears enable only
// R15 - byte, block, bulk erase act on latched byte, its block, whole array
// R16 - block and bulk erase leave the configuration byte alone
// R17 - wait mode does not disturb a running sequence
// R18 - stop halts sequence and pump, restarts after stop, blocks array access
// R19 - software should avoid stop during a sequence
// R20 - power-off bit disables array accesses; cleared by reset
// R21 - spare bit is read/write with no effect
// R22 - four 128-byte blocks, one protect bit each, ascending order
// R23 - timer ticks every 35 us from the programmed divisor
// R24 - security locks top 16 bytes of lower half, block/bulk, cfg byte
// R25 - auto bit set: hardware clears enable when the timer ends
// R26 - enable reads one for the whole automatic sequence
`timescale 1ns/1ns
`include "eps_defines.vh"
module eps_sequencer #(
  parameter PROG_TICKS     = 16'd286,
  parameter BYTE_ER_TICKS  = 16'd286,
  parameter BLOCK_ER_TICKS = 16'd286,
  parameter BULK_ER_TICKS  = 16'd286
) (
  // clock and reset
  input  wire        clk_sys,
  input  wire        resetn,
  // cpu bus
  input  wire [15:0] bus_addr,
  input  wire [7:0]  bus_wdata,
  input  wire        bus_wr,
  input  wire        bus_rd,
  output reg  [7:0]  bus_rdata,
  // low-power request pin
  input  wire        stop_req,
  // status to the analog side
  output reg         pump_on,
  output reg         seq_busy
);
  localparam S_IDLE = 2'h0;
  localparam S_RUN  = 2'h1;
  localparam S_DONE = 2'h2;
  localparam S_STOP = 2'h3;
  localparam [10:0] TB_DIV_RST = `EPS_TB_DIV_RST;

  // control register bits
  reg        spare_ctrl_bit_ff;
  reg        array_power_off_ff;
  reg [1:0]  op_mode_sel_ff;
  reg        bus_latch_ctrl_ff;
  reg        auto_term_ff;
  reg        prog_erase_enable_ff;
  // latched operation
  reg [9:0]  lat_idx_ff;
  reg [7:0]  lat_data_ff;
  reg        captured_ff;
  // configuration and timebase
  reg [7:0]  acr_ff;
  reg        acr_load_ff;
  reg [10:0] div_ff;
  // stop synchroniser
  reg        stop_s1_ff;
  reg        stop_s2_ff;
  reg        stop_s3_ff;
  reg        stop_ff;
  // sequence
  reg [1:0]  state_ff;
  reg [10:0] tb_cnt_ff;
  reg [15:0] tick_cnt_ff;
  reg        fail_ff;
  reg        restart_ff;
  reg        op_go_ff;
  reg [1:0]  op_mode_ff;

  wire [7:0] arr_byte;

  // {valid, index}; index bit 9 selects the configuration byte
  function [10:0] decode_addr;
    input [15:0] addr;
    begin
      if (addr >= `EPS_ARRAY_BASE && addr <= `EPS_ARRAY_LAST)
        decode_addr = {2'b10, addr[8:0]}; // R22
      else if (addr == `EPS_NVCFG_ADDR)
        decode_addr = {1'b1, `EPS_CFG_INDEX};
      else
        decode_addr = 11'h000;
    end
  endfunction

  function op_allowed;
    input [9:0] idx;
    input [1:0] mode;
    input [7:0] acr;
    reg secure;
    begin
      secure = ~acr[`EPS_ACR_SECURE];
      if (idx[9])
        op_allowed = ~secure && ~mode[1]; // R24
      else if (mode == `EPS_MODE_BULK_ER)
        op_allowed = ~secure; // R24
      else if (acr[idx[8:7]]) // R4
        op_allowed = 1'b0;
      else if (secure && (mode[1] || idx[8:4] == 5'h0f))
        op_allowed = 1'b0; // R24
      else
        op_allowed = 1'b1;
    end
  endfunction

  function [15:0] op_ticks;
    input [1:0] mode;
    begin
      case (mode)
        `EPS_MODE_PROG:     op_ticks = PROG_TICKS;
        `EPS_MODE_BYTE_ER:  op_ticks = BYTE_ER_TICKS;
        `EPS_MODE_BLOCK_ER: op_ticks = BLOCK_ER_TICKS;
        default:            op_ticks = BULK_ER_TICKS;
      endcase
    end
  endfunction

  wire [10:0] dec       = decode_addr(bus_addr);
  wire        arr_hit   = dec[10];
  wire [9:0]  arr_idx   = dec[9:0];
  wire        ctrl_wr   = bus_wr && bus_addr == `EPS_CTRL_ADDR;
  wire        ctrl_ok   = ctrl_wr && (!bus_latch_ctrl_ff || captured_ff); // R8
  wire        start     = ctrl_ok && bus_wdata[`EPS_CTRL_ENABLE] && !prog_erase_enable_ff
                          && bus_latch_ctrl_ff && captured_ff; // R9
  wire        tick      = tb_cnt_ff >= div_ff - 11'd1;
  wire        last_tick = tick && tick_cnt_ff >= op_ticks(op_mode_sel_ff) - 16'd1;

  eps_nvm_array u_array (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .op_go   (op_go_ff),
    .op_mode (op_mode_ff),
    .op_idx  (lat_idx_ff),
    .op_data (lat_data_ff),
    .blk_en  (~acr_ff[`EPS_ACR_PROT_HI:`EPS_ACR_PROT_LO]),
    .rd_idx  (acr_load_ff ? `EPS_CFG_INDEX : arr_idx),
    .rd_byte (arr_byte)
  );

  // stop pin: three stages, change taken when the last two agree
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      stop_s1_ff <= 1'b0;
      stop_s2_ff <= 1'b0;
      stop_s3_ff <= 1'b0;
      stop_ff    <= 1'b0;
    end else begin
      stop_s1_ff <= stop_req;
      stop_s2_ff <= stop_s1_ff;
      stop_s3_ff <= stop_s2_ff;
      if (stop_s2_ff == stop_s3_ff)
        stop_ff <= stop_s3_ff;
    end
  end

  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      spare_ctrl_bit_ff    <= 1'b0;
      array_power_off_ff   <= 1'b0; // R20
      op_mode_sel_ff       <= `EPS_MODE_PROG; // R5
      bus_latch_ctrl_ff    <= 1'b0; // R14
      auto_term_ff         <= 1'b0;
      prog_erase_enable_ff <= 1'b0;
      lat_idx_ff           <= 10'h000;
      lat_data_ff          <= 8'h00;
      captured_ff          <= 1'b0;
      acr_ff               <= 8'h00;
      acr_load_ff          <= 1'b1;
      div_ff               <= TB_DIV_RST;
      state_ff             <= S_IDLE;
      tb_cnt_ff            <= 11'h000;
      tick_cnt_ff          <= 16'h0000;
      fail_ff              <= 1'b0;
      restart_ff           <= 1'b0;
      op_go_ff             <= 1'b0;
      op_mode_ff           <= `EPS_MODE_PROG;
      bus_rdata            <= 8'h00;
      pump_on              <= 1'b0;
      seq_busy             <= 1'b0;
    end else begin
      op_go_ff <= 1'b0;
      // configuration copied from the nonvolatile byte after reset
      if (acr_load_ff) begin
        acr_ff      <= arr_byte;
        acr_load_ff <= 1'b0;
      end

      // control register write
      if (ctrl_ok) begin
        spare_ctrl_bit_ff  <= bus_wdata[`EPS_CTRL_SPARE]; // R21
        array_power_off_ff <= bus_wdata[`EPS_CTRL_OFF]; // R20
        auto_term_ff       <= bus_wdata[`EPS_CTRL_AUTO];
        if (!prog_erase_enable_ff)
          op_mode_sel_ff <= bus_wdata[`EPS_CTRL_MODE_HI:`EPS_CTRL_MODE_LO]; // R10
        // latch holds while enabled, so a joint clear drops enable only
        bus_latch_ctrl_ff <= bus_wdata[`EPS_CTRL_LATCH] | prog_erase_enable_ff; // R14
        if (!bus_wdata[`EPS_CTRL_LATCH] && !prog_erase_enable_ff)
          captured_ff <= 1'b0;
        if (!bus_wdata[`EPS_CTRL_ENABLE])
          prog_erase_enable_ff <= 1'b0;
        else if (start)
          prog_erase_enable_ff <= 1'b1; // R9
      end

      // divisor writable only with the latch clear
      if (bus_wr && !bus_latch_ctrl_ff && bus_addr == `EPS_DIV_HI_ADDR)
        div_ff[10:8] <= bus_wdata[2:0];
      if (bus_wr && !bus_latch_ctrl_ff && bus_addr == `EPS_DIV_LO_ADDR)
        div_ff[7:0] <= bus_wdata;

      // array write while latched: capture, last one wins
      if (bus_wr && arr_hit && bus_latch_ctrl_ff && !prog_erase_enable_ff) begin
        lat_idx_ff  <= arr_idx; // R6
        lat_data_ff <= bus_wdata; // R6
        captured_ff <= 1'b1;
      end

      // read path, one cycle after the strobe
      if (bus_rd) begin
        if (arr_hit) begin
          if (bus_latch_ctrl_ff) begin
            bus_rdata   <= lat_data_ff; // R7
            lat_idx_ff  <= arr_idx; // R7
            captured_ff <= 1'b1;
            // a read during the sequence spoils it
            if (prog_erase_enable_ff)
              fail_ff <= 1'b1; // R11
          end else if (array_power_off_ff || restart_ff) begin
            bus_rdata <= 8'h00; // R20
          end else begin
            bus_rdata <= arr_byte; // R1
            if (arr_idx[9])
              acr_ff <= arr_byte; // R4
          end
        end else begin
          case (bus_addr)
            `EPS_CTRL_ADDR:   bus_rdata <= {spare_ctrl_bit_ff, 1'b0, array_power_off_ff, op_mode_sel_ff,
                                            bus_latch_ctrl_ff, auto_term_ff, prog_erase_enable_ff};
            `EPS_ACR_ADDR:    bus_rdata <= acr_ff;
            `EPS_DIV_HI_ADDR: bus_rdata <= {5'h00, div_ff[10:8]};
            `EPS_DIV_LO_ADDR: bus_rdata <= div_ff[7:0];
            default:          bus_rdata <= 8'h00;
          endcase
        end
      end

      // timed sequence; wait mode has no input here and never halts it
      case (state_ff)
        S_IDLE: begin
          if (start) begin
            state_ff    <= S_RUN; // R10
            tb_cnt_ff   <= 11'h000;
            tick_cnt_ff <= 16'h0000;
            fail_ff     <= 1'b0;
            pump_on     <= 1'b1; // R10
            seq_busy    <= 1'b1;
          end
        end
        S_RUN: begin
          if (!prog_erase_enable_ff) begin
            // software abort: the operation is not applied
            state_ff <= S_IDLE;
            pump_on  <= 1'b0;
            seq_busy <= 1'b0;
          end else if (stop_ff) begin
            state_ff <= S_STOP; // R18
            pump_on  <= 1'b0; // R18
          end else begin
            tb_cnt_ff <= tick ? 11'h000 : tb_cnt_ff + 11'd1; // R23
            if (tick)
              tick_cnt_ff <= tick_cnt_ff + 16'd1; // R17
            if (last_tick) begin
              op_go_ff   <= !fail_ff && !array_power_off_ff &&
                            op_allowed(lat_idx_ff, op_mode_sel_ff, acr_ff); // R4
              op_mode_ff <= op_mode_sel_ff; // R15
              restart_ff <= 1'b0;
              seq_busy   <= 1'b0;
              if (auto_term_ff) begin
                // enable stays one until this very edge
                prog_erase_enable_ff <= 1'b0; // R25 R26 R12
                state_ff             <= S_IDLE;
                pump_on              <= 1'b0;
              end else begin
                state_ff <= S_DONE; // R13
              end
            end
          end
        end
        S_DONE: begin
          // manual mode: pump stays on until software clears enable or stop is taken
          if (!prog_erase_enable_ff) begin
            state_ff <= S_IDLE;
            pump_on  <= 1'b0;
          end else if (stop_ff) begin
            pump_on <= 1'b0; // R18
          end
        end
        S_STOP: begin
          if (!prog_erase_enable_ff) begin
            state_ff <= S_IDLE;
            seq_busy <= 1'b0;
          end else if (!stop_ff) begin
            // whole sequence starts over; array stays blocked meanwhile
            state_ff    <= S_RUN; // R18
            tb_cnt_ff   <= 11'h000;
            tick_cnt_ff <= 16'h0000;
            restart_ff  <= 1'b1; // R18
            pump_on     <= 1'b1;
          end
        end
        default: begin
          state_ff <= S_IDLE;
          pump_on  <= 1'b0;
          seq_busy <= 1'b0;
        end
      endcase
    end
  end
endmodule

// ### test/eps_cpu_model.sv
// cpu-side bus master issuing register and array accesses
`timescale 1ns/1ns
module eps_cpu_model (
  // clock
  input  wire        clk_sys,
  // bus drive
  output reg  [15:0] bus_addr,
  output reg  [7:0]  bus_wdata,
  output reg         bus_wr,
  output reg         bus_rd,
  // read data
  input  wire [7:0]  bus_rdata
);
  initial begin
    bus_addr = 16'h0000;
    bus_wdata = 8'h00;
    bus_wr = 1'b0;
    bus_rd = 1'b0;
  end
  // released lines show inverted values so stale data never looks valid
  task xfer(input logic wr, input logic [15:0] a, input logic [7:0] d, output logic [7:0] q);
    begin
      @(negedge clk_sys);
      bus_addr = a;
      bus_wdata = d;
      bus_wr = wr;
      bus_rd = !wr;
      @(negedge clk_sys);
      bus_wr = 1'b0;
      bus_rd = 1'b0;
      bus_addr = ~a;
      bus_wdata = ~d;
      @(negedge clk_sys);
      q = bus_rdata;
    end
  endtask
endmodule

// ### test/eps_seq_assertions.sv
// port-level property checker for the program/erase sequencer
`timescale 1ns/1ns
module eps_seq_assertions (
  // clock and reset
  input wire        clk_sys,
  input wire        resetn,
  // cpu bus
  input wire [15:0] bus_addr,
  input wire [7:0]  bus_wdata,
  input wire        bus_wr,
  input wire        bus_rd,
  input wire [7:0]  bus_rdata,
  // stop pin and status
  input wire        stop_req,
  input wire        pump_on,
  input wire        seq_busy
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  wire ctrl_rd;
  assign ctrl_rd = bus_rd && (bus_addr == 16'hfe1d);
  // six cycles covers the three-flop sync plus the output register
  property p_stop_off; stop_req [*6] |-> !pump_on; endproperty
  a_stop_off: assert property (p_stop_off) else $error("pump on during stop");
  property p_restart; (seq_busy && !stop_req) [*6] |-> pump_on; endproperty
  a_restart: assert property (p_restart) else $error("sequence not restarted");
  property p_pump_busy; $rose(pump_on) |-> seq_busy; endproperty
  a_pump_busy: assert property (p_pump_busy) else $error("pump without sequence");
  property p_busy_cause; $rose(seq_busy) |-> $past(bus_wr) || $past(bus_wr, 2); endproperty
  a_busy_cause: assert property (p_busy_cause) else $error("sequence without write");
  property p_en_latch; ctrl_rd |=> !(bus_rdata[0] && !bus_rdata[2]); endproperty
  a_en_latch: assert property (p_en_latch) else $error("enable without latch");
  property p_en_during; ctrl_rd && pump_on |=> bus_rdata[0]; endproperty
  a_en_during: assert property (p_en_during) else $error("enable low while pumping");
  property p_rd_hold; !bus_rd |=> $stable(bus_rdata); endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
  property p_low_zero; bus_rd && (bus_addr < 16'h0800) |=> bus_rdata == 8'h00; endproperty
  a_low_zero: assert property (p_low_zero) else $error("non-array read not zero");
endmodule

bind eps_sequencer eps_seq_assertions chk_u (
  .clk_sys   (clk_sys),
  .resetn    (resetn),
  .bus_addr  (bus_addr),
  .bus_wdata (bus_wdata),
  .bus_wr    (bus_wr),
  .bus_rd    (bus_rd),
  .bus_rdata (bus_rdata),
  .stop_req  (stop_req),
  .pump_on   (pump_on),
  .seq_busy  (seq_busy)
);

// ### test/test_eps_sequencer.sv
// self-checking bench for the program/erase sequencer
`timescale 1ns/1ns
module test_eps_sequencer;
  reg         clk_sys = 1'b0;
  reg         resetn = 1'b0;
  reg         stop_req = 1'b0;
  wire [15:0] bus_addr;
  wire [7:0]  bus_wdata;
  wire [7:0]  bus_rdata;
  wire        bus_wr;
  wire        bus_rd;
  wire        pump_on;
  wire        seq_busy;
  reg  [7:0]  q;
  reg  [32:0] rows [0:11];
  integer     error_cnt = 0;
  integer     compares = 0;
  integer     i;
  integer     n;

  always #20 clk_sys = ~clk_sys;

  eps_sequencer #(.PROG_TICKS(16'd2), .BYTE_ER_TICKS(16'd2), .BLOCK_ER_TICKS(16'd2),
                  .BULK_ER_TICKS(16'd2)) dut_u (
    .clk_sys(clk_sys), .resetn(resetn), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .stop_req(stop_req),
    .pump_on(pump_on), .seq_busy(seq_busy));
  eps_cpu_model cpu_u (
    .clk_sys(clk_sys), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata));

  task test_done;
    begin
      if (error_cnt == 0 && compares > 0)
        $display("TEST PASSED");
      else
        $display("TEST FAILED");
      $finish;
    end
  endtask
  task chk(input [95:0] nm, input [7:0] s, input [7:0] e);
    begin
      compares = compares + 1;
      if (s !== e) begin
        error_cnt = error_cnt + 1;
        $display("[ERR] %0s exp %h seen %h", nm, e, s);
      end
    end
  endtask
  task wr(input [15:0] a, input [7:0] d);
    cpu_u.xfer(1'b1, a, d, q);
  endtask
  task rd(input [15:0] a, input [7:0] e);
    begin
      cpu_u.xfer(1'b0, a, 8'h00, q);
      chk("read", q, e);
    end
  endtask
  // latch with auto, capture, enable
  task go(input [1:0] m, input [15:0] a, input [7:0] d);
    begin
      wr(16'hfe1d, {3'b000, m, 3'b110});
      wr(a, d);
      wr(16'hfe1d, {3'b000, m, 3'b111});
    end
  endtask
  // poll rather than time the sequence; only the control register is read meanwhile
  task fin;
    begin
      n = 0;
      q = 8'h01;
      while (q[0] === 1'b1 && n < 400) begin
        cpu_u.xfer(1'b0, 16'hfe1d, 8'h00, q);
        n = n + 1;
      end
      chk("auto clear", {7'h00, q[0]}, 8'h00);
      wr(16'hfe1d, 8'h00);
    end
  endtask
  task op(input [1:0] m, input [15:0] a, input [7:0] d);
    begin
      go(m, a, d);
      fin;
    end
  endtask

  // 50000 cycles, well over the couple of hundred cycles any one sequence needs here
  initial begin
    #2000000;
    error_cnt = error_cnt + 1;
    test_done;
  end

  initial begin
    rows[0] = {1'b0, 16'hfe1d, 8'h00, 8'h00};
    rows[1] = {1'b0, 16'hfe1f, 8'h00, 8'h10};
    rows[2] = {1'b0, 16'hfe1c, 8'h00, 8'h10};
    rows[3] = {1'b0, 16'h0800, 8'h00, 8'hff};
    rows[4] = {1'b0, 16'h09ff, 8'h00, 8'hff};
    rows[5] = {1'b0, 16'h0000, 8'h00, 8'h00};
    rows[6] = {1'b1, 16'hfe1a, 8'h00, 8'h00};
    rows[7] = {1'b1, 16'hfe1b, 8'h02, 8'h00};
    rows[8] = {1'b0, 16'hfe1b, 8'h00, 8'h02};
    rows[9] = {1'b1, 16'hfe1d, 8'h80, 8'h00};
    rows[10] = {1'b0, 16'hfe1d, 8'h00, 8'h80};
    rows[11] = {1'b1, 16'hfe1d, 8'h00, 8'h00};
    repeat (10) @(negedge clk_sys);
    resetn = 1'b1;
    repeat (2) @(negedge clk_sys);
    for (i = 0; i < 12; i = i + 1) begin
      cpu_u.xfer(rows[i][32], rows[i][31:16], rows[i][15:8], q);
      if (!rows[i][32])
        chk("table", q, rows[i][7:0]);
    end
    op(2'h0, 16'h0800, 8'h5a);
    rd(16'h0800, 8'h5a);
    op(2'h0, 16'h0800, 8'ha5);
    rd(16'h0800, 8'h00);
    op(2'h0, 16'h0801, 8'h0f);
    op(2'h0, 16'h0880, 8'h33);
    op(2'h1, 16'h0800, 8'h00);
    rd(16'h0800, 8'hff);
    rd(16'h0801, 8'h0f);
    op(2'h2, 16'h0801, 8'h00);
    rd(16'h0801, 8'hff);
    rd(16'h0880, 8'h33);
    op(2'h3, 16'h09ff, 8'h00);
    rd(16'h0880, 8'hff);
    rd(16'hfe1c, 8'h10);
    op(2'h1, 16'hfe1c, 8'h00);
    rd(16'hfe1c, 8'hff);
    rd(16'hfe1f, 8'hff);
    op(2'h0, 16'h0900, 8'h00);
    rd(16'h0900, 8'hff);
    op(2'h0, 16'hfe1c, 8'h10);
    rd(16'hfe1c, 8'h10);
    rd(16'hfe1f, 8'h10);
    wr(16'hfe1d, 8'h01);
    rd(16'hfe1d, 8'h00);
    wr(16'hfe1d, 8'h04);
    wr(16'h0000, 8'h12);
    wr(16'hfe1d, 8'h00);
    rd(16'hfe1d, 8'h04);
    wr(16'h0810, 8'hc3);
    rd(16'h0812, 8'hc3);
    wr(16'hfe1d, 8'h05);
    chk("pump", {7'h00, pump_on}, 8'h01);
    wr(16'hfe1d, 8'h1d);
    rd(16'hfe1d, 8'h05);
    repeat (20) @(negedge clk_sys);
    wr(16'hfe1d, 8'h00);
    rd(16'hfe1d, 8'h04);
    repeat (4) @(negedge clk_sys);
    wr(16'hfe1d, 8'h00);
    rd(16'h0812, 8'hc3);
    rd(16'h0810, 8'hff);
    wr(16'hfe1d, 8'h20);
    rd(16'h0800, 8'h00);
    wr(16'hfe1d, 8'h00);
    rd(16'h0800, 8'hff);
    wr(16'hfe1b, 8'h40);
    go(2'h0, 16'h0900, 8'h77);
    stop_req = 1'b1;
    repeat (10) @(negedge clk_sys);
    chk("stopped", {6'h00, pump_on, seq_busy}, 8'h01);
    stop_req = 1'b0;
    repeat (10) @(negedge clk_sys);
    chk("restart", {6'h00, pump_on, seq_busy}, 8'h03);
    fin;
    rd(16'h0900, 8'h77);
    go(2'h0, 16'h0820, 8'h00);
    rd(16'h0820, 8'h00);
    fin;
    rd(16'h0820, 8'hff);
    op(2'h0, 16'hfe1c, 8'h00);
    rd(16'hfe1c, 8'h00);
    op(2'h2, 16'h0900, 8'h00);
    rd(16'h0900, 8'h77);
    op(2'h0, 16'h08f0, 8'h00);
    rd(16'h08f0, 8'hff);
    op(2'h1, 16'h0900, 8'h00);
    rd(16'h0900, 8'hff);
    wr(16'hfe1d, 8'h18);
    resetn = 1'b0;
    repeat (2) @(negedge clk_sys);
    resetn = 1'b1;
    repeat (2) @(negedge clk_sys);
    rd(16'hfe1d, 8'h00);
    test_done;
  end
endmodule
